// ---- pkg/ssb_pkg.sv ----
// Shared constants and types for the synchronous serial boot loader.
package ssb_pkg;
  localparam int WORD_W = 18;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h11;
  localparam int MEM_AW = 6;
  localparam int MEM_DEPTH = 64;
  localparam int HDR_WORDS = 3;
  // Header word positions within the three-word header.
  localparam logic [1:0] HDR_EXEC = 2'h0;
  localparam logic [1:0] HDR_DEST = 2'h1;
  localparam logic [1:0] HDR_COUNT = 2'h2;
  // Execution address that means "read the next header".
  localparam logic [WORD_W-1:0] HDR_ENTRY_ADDR = 18'h000a9;
  localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 5'h00;

  typedef enum logic [1:0] {
    SSB_MODE_BOOT = 2'b00,
    SSB_MODE_COPY = 2'b01,
    SSB_MODE_SINGLE = 2'b10
  } ssb_mode_t;

  typedef enum logic [1:0] {
    SSB_ST_IDLE = 2'b00,
    SSB_ST_HDR = 2'b01,
    SSB_ST_LOAD = 2'b10,
    SSB_ST_SINGLE = 2'b11
  } ssb_state_t;
endpackage : ssb_pkg

// ---- src/ssb_deser.sv ----
// Link sampler that turns both-edge serial bits into 18-bit words.
`timescale 1ns/1ps
module ssb_deser (
  input wire logic clk,
  input wire logic reset,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  output logic word_v,
  output logic [ssb_pkg::WORD_W-1:0] word
);
  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic dat_s1_q, dat_s2_q;
  logic armed_q;
  logic [ssb_pkg::BIT_CNT_W-1:0] bit_cnt_q;
  logic [ssb_pkg::WORD_W-1:0] shift_q;
  logic edge_seen;
  logic take;

  // Pins are synchronised; the link runs far slower than clk, so each bit is
  // taken well inside one link period.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dat_s1_q <= 1'b0;
      dat_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= ser_clk_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= ser_data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  assign edge_seen = clk_s2_q ^ clk_s3_q;
  // Every edge carries a bit, but input only begins at the first rising one.
  assign take = edge_seen && (armed_q || clk_s2_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      armed_q <= 1'b0;
    end else if (take) begin
      armed_q <= 1'b1;
    end
  end

  // No handshake between words: counting simply rolls into the next word.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_cnt_q <= ssb_pkg::BIT_CNT_RESET;
    end else if (take) begin
      bit_cnt_q <= (bit_cnt_q == ssb_pkg::LAST_BIT) ? ssb_pkg::BIT_CNT_RESET
                                                   : bit_cnt_q + 5'h01;
    end
  end

  // First bit lands in the top position after 18 shifts.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= ssb_pkg::WORD_RESET;
      word <= ssb_pkg::WORD_RESET;
      word_v <= 1'b0;
    end else begin
      word_v <= take && (bit_cnt_q == ssb_pkg::LAST_BIT);
      if (take) begin
        shift_q <= {shift_q[ssb_pkg::WORD_W-2:0], dat_s2_q};
        if (bit_cnt_q == ssb_pkg::LAST_BIT) begin
          word <= {shift_q[ssb_pkg::WORD_W-2:0], dat_s2_q};
        end
      end
    end
  end

  a_word_after_last: assert property (@(posedge clk) disable iff (reset)
    (take && bit_cnt_q == ssb_pkg::LAST_BIT) |=> word_v && word[0] == $past(dat_s2_q))
    else $error("word not completed on the eighteenth bit");
  a_no_bit_unarmed: assert property (@(posedge clk) disable iff (reset)
    (!armed_q && edge_seen && !clk_s2_q) |=> $stable(bit_cnt_q))
    else $error("bit taken before the first rising edge");
  a_both_edges: assert property (@(posedge clk) disable iff (reset)
    (armed_q && edge_seen) |=> bit_cnt_q != $past(bit_cnt_q))
    else $error("an armed link edge did not advance the bit count");
endmodule : ssb_deser

// ---- src/ssb_loader.sv ----
// Synchronous serial boot loader: header parsing, copy, single word, memory.
//
// How it works
// - Link clock on bit 17, data on bit 1.
// - Receive only; data pin never driven.
// - Only whole 18-bit words are transferred.
// - One bit on every clock edge.
// - First rising edge starts input, samples bit.
// - No handshake between words; counting continues.
// - Take each bit within one link period.
// - Boot: header, load sub-stream, then jump.
// - Header entry as exec address chains streams.
// - Copy mode takes count, destination, continuation.
// - Words stored at consecutive destination addresses.
// - Single mode returns one word, no argument.
// - Header is exec, destination, then count.
`timescale 1ns/1ps
module ssb_loader (
  input wire logic clk,
  input wire logic reset,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_mode,
  input wire logic [ssb_pkg::WORD_W-1:0] copy_count,
  input wire logic [ssb_pkg::WORD_W-1:0] copy_dest,
  input wire logic [ssb_pkg::WORD_W-1:0] copy_exec,
  output logic busy,
  output logic word_valid,
  output logic [ssb_pkg::WORD_W-1:0] word_data,
  output logic jump_valid,
  output logic [ssb_pkg::WORD_W-1:0] jump_addr,
  input wire logic [ssb_pkg::MEM_AW-1:0] rd_addr,
  output logic [ssb_pkg::WORD_W-1:0] rd_data
);
  ssb_pkg::ssb_state_t state_q;
  logic [1:0] hdr_idx_q;
  logic [ssb_pkg::WORD_W-1:0] exec_q, dest_q, cnt_q;
  logic [ssb_pkg::WORD_W-1:0] mem [ssb_pkg::MEM_DEPTH];
  logic word_v;
  logic [ssb_pkg::WORD_W-1:0] word;
  logic hdr_last, load_last, fin, chain, start;

  ssb_deser u_deser (
    .clk(clk),
    .reset(reset),
    .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in),
    .word_v(word_v),
    .word(word)
  );

  // The link clock is only ever an input, and the data pin stays released.
  assign ser_data_out = 1'b0;
  assign ser_data_oe = 1'b0;

  assign start = cmd_valid && (state_q == ssb_pkg::SSB_ST_IDLE);
  assign busy = (state_q != ssb_pkg::SSB_ST_IDLE);
  assign hdr_last = (state_q == ssb_pkg::SSB_ST_HDR) && word_v &&
                    (hdr_idx_q == ssb_pkg::HDR_COUNT) && (word == ssb_pkg::WORD_RESET);
  assign load_last = (state_q == ssb_pkg::SSB_ST_LOAD) && word_v &&
                     (cnt_q == 18'h00001);
  assign fin = hdr_last || load_last;
  // A sub-stream whose exec address is the header entry goes on to the next header.
  assign chain = (exec_q == ssb_pkg::HDR_ENTRY_ADDR);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ssb_pkg::SSB_ST_IDLE;
    end else begin
      case (state_q)
        ssb_pkg::SSB_ST_IDLE: begin
          if (start) begin
            case (cmd_mode)
              ssb_pkg::SSB_MODE_BOOT: state_q <= ssb_pkg::SSB_ST_HDR;
              ssb_pkg::SSB_MODE_COPY: begin
                state_q <= (copy_count == ssb_pkg::WORD_RESET) ? ssb_pkg::SSB_ST_IDLE
                                                               : ssb_pkg::SSB_ST_LOAD;
              end
              ssb_pkg::SSB_MODE_SINGLE: state_q <= ssb_pkg::SSB_ST_SINGLE;
              default: state_q <= ssb_pkg::SSB_ST_IDLE;
            endcase
          end
        end
        ssb_pkg::SSB_ST_HDR: begin
          if (word_v && hdr_idx_q == ssb_pkg::HDR_COUNT) begin
            state_q <= fin ? (chain ? ssb_pkg::SSB_ST_HDR : ssb_pkg::SSB_ST_IDLE)
                           : ssb_pkg::SSB_ST_LOAD;
          end
        end
        ssb_pkg::SSB_ST_LOAD: begin
          if (fin) begin
            state_q <= chain ? ssb_pkg::SSB_ST_HDR : ssb_pkg::SSB_ST_IDLE;
          end
        end
        ssb_pkg::SSB_ST_SINGLE: begin
          if (word_v) begin
            state_q <= ssb_pkg::SSB_ST_IDLE;
          end
        end
        default: state_q <= ssb_pkg::SSB_ST_IDLE;
      endcase
    end
  end

  // Header fields arrive as execution address, destination, then count.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hdr_idx_q <= ssb_pkg::HDR_EXEC;
      exec_q <= ssb_pkg::WORD_RESET;
      dest_q <= ssb_pkg::WORD_RESET;
      cnt_q <= ssb_pkg::WORD_RESET;
    end else if (start && cmd_mode == ssb_pkg::SSB_MODE_COPY) begin
      exec_q <= copy_exec;
      dest_q <= copy_dest;
      cnt_q <= copy_count;
    end else if (state_q == ssb_pkg::SSB_ST_HDR && word_v) begin
      hdr_idx_q <= (hdr_idx_q == ssb_pkg::HDR_COUNT) ? ssb_pkg::HDR_EXEC
                                                     : hdr_idx_q + 2'h1;
      case (hdr_idx_q)
        ssb_pkg::HDR_EXEC: exec_q <= word;
        ssb_pkg::HDR_DEST: dest_q <= word;
        ssb_pkg::HDR_COUNT: cnt_q <= word;
        default: cnt_q <= cnt_q;
      endcase
    end else if (state_q == ssb_pkg::SSB_ST_LOAD && word_v) begin
      dest_q <= dest_q + 18'h00001;
      cnt_q <= cnt_q - 18'h00001;
    end
  end

  // Memory wraps on the low address bits; a larger image needs a deeper array.
  always_ff @(posedge clk) begin
    if (state_q == ssb_pkg::SSB_ST_LOAD && word_v) begin
      mem[dest_q[ssb_pkg::MEM_AW-1:0]] <= word;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= ssb_pkg::WORD_RESET;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

  // A copy of zero words jumps at once to its continuation.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      jump_valid <= 1'b0;
      jump_addr <= ssb_pkg::WORD_RESET;
    end else begin
      jump_valid <= 1'b0;
      if (fin && !chain) begin
        jump_valid <= 1'b1;
        jump_addr <= exec_q;
      end else if (start && cmd_mode == ssb_pkg::SSB_MODE_COPY &&
                   copy_count == ssb_pkg::WORD_RESET) begin
        jump_valid <= 1'b1;
        jump_addr <= copy_exec;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_valid <= 1'b0;
      word_data <= ssb_pkg::WORD_RESET;
    end else begin
      word_valid <= (state_q == ssb_pkg::SSB_ST_SINGLE) && word_v;
      if ((state_q == ssb_pkg::SSB_ST_SINGLE) && word_v) begin
        word_data <= word;
      end
    end
  end

  sequence s_boot_start;
    start && cmd_mode == ssb_pkg::SSB_MODE_BOOT;
  endsequence
  sequence s_in_header;
    state_q == ssb_pkg::SSB_ST_HDR && hdr_idx_q == ssb_pkg::HDR_EXEC;
  endsequence

  a_pin_released: assert property (@(posedge clk) disable iff (reset)
    !ser_data_oe)
    else $error("data pin driven");
  a_boot_header: assert property (@(posedge clk) disable iff (reset)
    s_boot_start |=> s_in_header)
    else $error("boot did not begin with the header");
  a_exec_field: assert property (@(posedge clk) disable iff (reset)
    (state_q == ssb_pkg::SSB_ST_HDR && hdr_idx_q == ssb_pkg::HDR_EXEC && word_v)
    |=> exec_q == $past(word) && hdr_idx_q == ssb_pkg::HDR_DEST)
    else $error("first header word not taken as exec address");
  a_jump_exec: assert property (@(posedge clk) disable iff (reset)
    (fin && !chain) |=> jump_valid && jump_addr == $past(exec_q)
    && state_q == ssb_pkg::SSB_ST_IDLE)
    else $error("no jump to the exec address");
  a_chain_next: assert property (@(posedge clk) disable iff (reset)
    (fin && chain) |=> !jump_valid ##0 s_in_header)
    else $error("chained sub-stream did not return to the header");
  a_copy_load: assert property (@(posedge clk) disable iff (reset)
    (start && cmd_mode == ssb_pkg::SSB_MODE_COPY && copy_count != ssb_pkg::WORD_RESET)
    |=> state_q == ssb_pkg::SSB_ST_LOAD && cnt_q == $past(copy_count)
    && dest_q == $past(copy_dest))
    else $error("copy did not load its arguments");
  a_mem_store: assert property (@(posedge clk) disable iff (reset)
    (state_q == ssb_pkg::SSB_ST_LOAD && word_v) |=>
    mem[$past(dest_q[ssb_pkg::MEM_AW-1:0])] == $past(word)
    && dest_q == $past(dest_q) + 18'h00001)
    else $error("word not stored at the destination");
  a_single_word: assert property (@(posedge clk) disable iff (reset)
    (state_q == ssb_pkg::SSB_ST_SINGLE && word_v) |=> word_valid
    && word_data == $past(word) ##1 !word_valid)
    else $error("single word not handed back");
endmodule : ssb_loader

// ---- dv/ssb_host_model.sv ----
// Behavioural outside agent that clocks 18-bit words into the link.
`timescale 1ns/1ps
module ssb_host_model (
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
  end
  // Whole words only, back to back, with no handshake between them.
  task automatic send_word(input logic [17:0] w);
    for (int i = 17; i >= 0; i--) begin
      link_data = w[i];
      #100;
      link_clk = ~link_clk;
      #100;
    end
    // The released line shows the inverse so a stale bit is never mistaken for data.
    link_data = ~w[0];
  endtask : send_word
endmodule : ssb_host_model

// ---- dv/ssb_loader_tb.sv ----
// Self-checking bench for the serial boot loader.
`timescale 1ns/1ps
module ssb_loader_tb;
  typedef struct packed {
    logic [17:0] din;
    logic [17:0] dout;
  } ssb_row_t;
  logic clk, reset, ser_clk_in, ser_data_in, ser_data_out, ser_data_oe;
  logic cmd_valid, busy, word_valid, jump_valid;
  logic [1:0] cmd_mode;
  logic [17:0] copy_count, copy_dest, copy_exec, word_data, jump_addr, rd_data;
  logic [17:0] got_word, got_jump;
  logic [5:0] rd_addr;
  int bad_count = 0;
  int n_tests = 0;
  int jumps = 0;
  int j0;
  // The second row is not bit-symmetric, so a reversed word shows up.
  ssb_row_t rows [4] = '{'{18'h00000, 18'h00000}, '{18'h20003, 18'h20003},
    '{18'h1b2c3, 18'h1b2c3}, '{18'h3fffe, 18'h3fffe}};

  // Clock rides the bit 17 pin and data the bit 1 pin.
  ssb_host_model host (.link_clk(ser_clk_in), .link_data(ser_data_in));
  ssb_loader uut (.clk(clk), .reset(reset), .ser_clk_in(ser_clk_in),
    .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
    .cmd_valid(cmd_valid), .cmd_mode(cmd_mode), .copy_count(copy_count),
    .copy_dest(copy_dest), .copy_exec(copy_exec), .busy(busy), .word_valid(word_valid),
    .word_data(word_data), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .rd_addr(rd_addr), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulses last one cycle, so they are caught here rather than polled.
  always @(posedge clk) begin
    if (word_valid === 1'b1) got_word <= word_data;
    if (jump_valid === 1'b1) begin
      got_jump <= jump_addr;
      jumps <= jumps + 1;
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_word(input string nm, input logic [17:0] e, input logic [17:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic issue(input logic [1:0] m, input logic [17:0] c, d, e);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_mode <= m;
    copy_count <= c;
    copy_dest <= d;
    copy_exec <= e;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic send_list(input logic [17:0] q[$]);
    foreach (q[i]) host.send_word(q[i]);
  endtask : send_list

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (busy !== 1'b0 && k < 40);
    if (busy !== 1'b0) begin
      bad_count++;
      close_out();
    end
    // Pulses rise as busy falls; one more edge lets the catcher latch them.
    @(posedge clk);
    #1;
  endtask : wait_idle

  task automatic read_mem(input logic [5:0] a, input logic [17:0] e);
    @(posedge clk);
    rd_addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk_word("memory word", e, rd_data);
  endtask : read_mem

  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_mode = 2'h0;
    copy_count = 18'h00000;
    copy_dest = 18'h00000;
    copy_exec = 18'h00000;
    rd_addr = 6'h00;
    repeat (6) @(posedge clk);
    #1;
    chk_bit("busy in reset", 1'b0, busy);
    chk_bit("jump in reset", 1'b0, jump_valid);
    chk_word("rd_data in reset", 18'h00000, rd_data);
    chk_bit("data out in reset", 1'b0, ser_data_out);
    @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      issue(2'h2, 18'h00000, 18'h00000, 18'h00000);
      host.send_word(rows[i].din);
      wait_idle();
      chk_word("single word", rows[i].dout, got_word);
      chk_bit("data oe", 1'b0, ser_data_oe);
      chk_bit("data out", 1'b0, ser_data_out);
    end
    j0 = jumps;
    issue(2'h0, 18'h00000, 18'h00000, 18'h00000);
    chk_bit("boot busy", 1'b1, busy);
    send_list('{18'h00123, 18'h00005, 18'h00002, 18'h3ffff, 18'h2aaaa});
    wait_idle();
    chk_word("boot jump", 18'h00123, got_jump);
    read_mem(6'h05, 18'h3ffff);
    read_mem(6'h06, 18'h2aaaa);
    issue(2'h0, 18'h00000, 18'h00000, 18'h00000);
    send_list('{ssb_pkg::HDR_ENTRY_ADDR, 18'h0003e, 18'h00003, 18'h00001, 18'h00002,
      18'h00003, 18'h00777, 18'h00010, 18'h00000});
    wait_idle();
    chk_word("chain jump", 18'h00777, got_jump);
    chk_word("jump count", 18'(j0 + 2), 18'(jumps));
    read_mem(6'h3e, 18'h00001);
    read_mem(6'h00, 18'h00003);
    issue(2'h1, 18'h00002, 18'h00020, 18'h00abc);
    send_list('{18'h0aaaa, 18'h05555});
    wait_idle();
    chk_word("copy jump", 18'h00abc, got_jump);
    read_mem(6'h21, 18'h05555);
    issue(2'h1, 18'h00000, 18'h00000, 18'h00def);
    wait_idle();
    chk_word("empty copy jump", 18'h00def, got_jump);
    j0 = jumps;
    issue(2'h3, 18'h00000, 18'h00000, 18'h00000);
    chk_bit("reserved mode busy", 1'b0, busy);
    issue(2'h2, 18'h00000, 18'h00000, 18'h00000);
    issue(2'h0, 18'h00000, 18'h00000, 18'h00000);
    host.send_word(18'h15a5a);
    wait_idle();
    repeat (4) @(posedge clk);
    #1;
    chk_word("single after refusal", 18'h15a5a, got_word);
    chk_bit("refused boot busy", 1'b0, busy);
    chk_word("no stray jump", 18'(j0), 18'(jumps));
    close_out();
  end
endmodule : ssb_loader_tb
